// ==== shared/cam_pkg.sv ====
// Constants, types and register layout of the counter array control and mode block.
// Notes on behaviour
// (R1) Counter wrap from 0xffff sets overflow flag.
// (R2) Flags cleared only by software writes.
// (R3) Overflow flag requests interrupt when enabled.
// (R4) Run bit 6 stops or runs counter.
// (R5) Module flags bits 0-4 set on match/capture.
// (R6) Enabled module flag requests shared interrupt.
// (R7) Unused bits read zero, writes ignored.
// (R8) Idle suspend bit 7 freezes array in idle.
// (R9) Watchdog enable bit 6 makes module 4 watchdog.
// (R10) Lock bit 5 keeps watchdog enabled until reset.
// (R11) Timebase select picks counter increment source.
// (R12) External input counts falling edges, quarter rate.
// (R13) External clock divided by eight, synchronised.
// (R14) Watchdog enabled blocks other mode bit writes.
// (R15) Reset sets watchdog enable, others zero.
// (R16) Compare high byte match gives watchdog reset.
// (R17) Watchdog forces counter running, run writes ignored; code stores run bit writes, which act once watchdog is off.
// (R18) Writing module 4 flag one forces reset.
// (R19) Counter adds one per timebase event, wraps.
package cam_pkg;

   // ----------------------------------------------------------------------
   // Register addresses and fields
   // ----------------------------------------------------------------------
   localparam logic [7:0] CAM_CTL_ADDR = 8'hd8;
   localparam logic [7:0] CAM_MODE_ADDR = 8'hd9;

   localparam int CAM_CTL_OVF = 7;
   localparam int CAM_CTL_RUN = 6;
   localparam int CAM_CTL_UNUSED = 5;
   localparam int CAM_CTL_MOD4 = 4;
   localparam int CAM_NUM_MOD = 5;

   localparam int CAM_MODE_IDLE = 7;
   localparam int CAM_MODE_WDE = 6;
   localparam int CAM_MODE_LOCK = 5;
   localparam int CAM_MODE_UNUSED = 4;
   localparam int CAM_MODE_TB_HI = 3;
   localparam int CAM_MODE_TB_LO = 1;
   localparam int CAM_MODE_OVF_IE = 0;

   localparam logic [7:0] CAM_CTL_RESET = 8'h00;
   localparam logic [7:0] CAM_MODE_RESET = 8'h40;

   // ----------------------------------------------------------------------
   // Counter and timebase constants
   // ----------------------------------------------------------------------
   localparam logic [15:0] CAM_CNT_MAX = 16'hffff;
   localparam logic [7:0] CAM_LOW_MAX = 8'hff;
   localparam logic [3:0] CAM_DIV12_LAST = 4'hb;
   localparam logic [3:0] CAM_DIV4_LAST = 4'h3;
   localparam logic [2:0] CAM_EXT_DIV_LAST = 3'h7;

   typedef enum logic [2:0] {
      CAM_TB_DIV12 = 3'h0,
      CAM_TB_DIV4 = 3'h1,
      CAM_TB_TMR0 = 3'h2,
      CAM_TB_EXTIN = 3'h3,
      CAM_TB_SYSTEM_CLOCK = 3'h4,
      CAM_TB_EXTCLK = 3'h5
   } cam_tb_t;

   // ----------------------------------------------------------------------
   // Special-function-register access from the processor
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cam_sfr_t;

endpackage : cam_pkg

// ==== rtl/cam_ctrl.sv ====
// Control and mode registers, timebase and counter of the counter array.
`timescale 1ns/10ps
module cam_ctrl
   import cam_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Processor register access
   input cam_sfr_t sfr,
   output logic [7:0] sfr_rdata_r,
   // Events from the capture/compare modules and the system
   input wire logic [CAM_NUM_MOD-1:0] module_match,
   input wire logic [CAM_NUM_MOD-1:0] module_irq_enable,
   input wire logic timer0_overflow,
   input wire logic cpu_idle,
   input wire logic [7:0] module4_compare_high,
   // Pins
   input wire logic external_count_input,
   input wire logic external_clock,
   // Results
   output logic [15:0] counter_r,
   output logic irq_r,
   output logic watchdog_reset_r
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [7:0] ctl_r;
   logic [7:0] ctl_nxt;
   logic [7:0] mode_r;
   logic [7:0] mode_nxt;
   logic [3:0] presc_r;
   logic [2:0] ext_div_r;
   logic [2:0] eci_sync_r;
   logic [2:0] eclk_sync_r;
   logic tick;
   logic active;
   logic running;
   logic low_wrap;
   logic eci_fall;
   logic eclk_rise;
   logic ctl_wr;
   logic mode_wr;
   logic wd_en;
   logic [15:0] counter_nxt;

   function automatic logic sfr_hit(input cam_sfr_t s, input logic [7:0] a);
      sfr_hit = s.addr == a;
   endfunction : sfr_hit

   assign ctl_wr = sfr.wr && sfr_hit(sfr, CAM_CTL_ADDR);
   assign mode_wr = sfr.wr && sfr_hit(sfr, CAM_MODE_ADDR);
   assign wd_en = mode_r[CAM_MODE_WDE];
   assign active = !(mode_r[CAM_MODE_IDLE] && cpu_idle); // see (R8)
   assign running = ctl_r[CAM_CTL_RUN] || wd_en; // see (R4) see (R17)

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         eci_sync_r <= 3'h0;
         eclk_sync_r <= 3'h0;
      end else begin
         eci_sync_r <= {eci_sync_r[1:0], external_count_input};
         eclk_sync_r <= {eclk_sync_r[1:0], external_clock};
      end
   end

   // Edge detectors look only at the second and third stages.
   assign eci_fall = eci_sync_r[2] && !eci_sync_r[1]; // see (R12)
   assign eclk_rise = eclk_sync_r[1] && !eclk_sync_r[2];

   // ----------------------------------------------------------------------
   // Timebase
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         presc_r <= 4'h0;
      end else if (active) begin
         if ((mode_r[CAM_MODE_TB_HI:CAM_MODE_TB_LO] == CAM_TB_DIV12 && presc_r == CAM_DIV12_LAST) ||
             (mode_r[CAM_MODE_TB_HI:CAM_MODE_TB_LO] == CAM_TB_DIV4 && presc_r == CAM_DIV4_LAST) ||
             presc_r >= CAM_DIV12_LAST) begin
            presc_r <= 4'h0;
         end else begin
            presc_r <= presc_r + 4'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_div_r <= 3'h0;
      end else if (active && eclk_rise) begin
         ext_div_r <= ext_div_r + 3'h1; // see (R13)
      end
   end

   always_comb begin
      tick = 1'b0;
      unique case (mode_r[CAM_MODE_TB_HI:CAM_MODE_TB_LO]) // see (R11)
         CAM_TB_DIV12: tick = presc_r == CAM_DIV12_LAST;
         CAM_TB_DIV4: tick = presc_r == CAM_DIV4_LAST;
         CAM_TB_TMR0: tick = timer0_overflow;
         CAM_TB_EXTIN: tick = eci_fall;
         CAM_TB_SYSTEM_CLOCK: tick = 1'b1;
         CAM_TB_EXTCLK: tick = eclk_rise && ext_div_r == CAM_EXT_DIV_LAST; // see (R13)
         default: tick = 1'b0;
      endcase
      tick = tick && active && running;
   end

   // ----------------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------------
   assign counter_nxt = counter_r + 16'h0001;
   assign low_wrap = tick && counter_r[7:0] == CAM_LOW_MAX;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         counter_r <= 16'h0000;
      end else if (tick) begin
         counter_r <= counter_nxt; // see (R19)
      end
   end

   // ----------------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------------
   always_comb begin
      ctl_nxt = ctl_r;
      if (ctl_wr) begin
         ctl_nxt = sfr.wdata;
      end
      ctl_nxt[CAM_CTL_UNUSED] = 1'b0; // see (R7)
      // Hardware sets win over a software clear in the same cycle.
      if (tick && counter_r == CAM_CNT_MAX) begin
         ctl_nxt[CAM_CTL_OVF] = 1'b1; // see (R1) see (R2)
      end
      for (int i = 0; i < CAM_NUM_MOD; i++) begin
         if (module_match[i] && active) begin
            ctl_nxt[i] = 1'b1; // see (R5) see (R2)
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctl_r <= CAM_CTL_RESET;
      end else begin
         ctl_r <= ctl_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Mode register
   // ----------------------------------------------------------------------
   always_comb begin
      mode_nxt = mode_r;
      if (mode_wr) begin
         if (!wd_en) begin
            mode_nxt = sfr.wdata;
            // Setting the lock also turns the watchdog on.
            mode_nxt[CAM_MODE_WDE] = sfr.wdata[CAM_MODE_WDE] || sfr.wdata[CAM_MODE_LOCK];
         end else if (!mode_r[CAM_MODE_LOCK]) begin
            mode_nxt[CAM_MODE_WDE] = sfr.wdata[CAM_MODE_WDE]; // see (R14) see (R10)
         end
      end
      mode_nxt[CAM_MODE_UNUSED] = 1'b0; // see (R7)
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode_r <= CAM_MODE_RESET; // see (R15)
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Read data, interrupt and watchdog reset
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sfr_rdata_r <= 8'h00;
      end else if (sfr.rd) begin
         if (sfr_hit(sfr, CAM_CTL_ADDR)) begin
            sfr_rdata_r <= ctl_r;
         end else if (sfr_hit(sfr, CAM_MODE_ADDR)) begin
            sfr_rdata_r <= mode_r;
         end else begin
            sfr_rdata_r <= 8'h00;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= (ctl_r[CAM_CTL_OVF] && mode_r[CAM_MODE_OVF_IE]) || // see (R3)
                  |(ctl_r[CAM_NUM_MOD-1:0] & module_irq_enable); // see (R6)
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         watchdog_reset_r <= 1'b0;
      end else begin
         watchdog_reset_r <= wd_en && // see (R9)
                             ((low_wrap && module4_compare_high == counter_r[15:8]) || // see (R16)
                              (ctl_wr && sfr.wdata[CAM_CTL_MOD4])); // see (R18)
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   chk_ovf_flag_set: assert property (@(posedge clk) disable iff (!nrst) // see (R1)
      tick && counter_r == CAM_CNT_MAX |=> ctl_r[CAM_CTL_OVF] && counter_r == 16'h0000)
      else $error("overflow flag not set on wrap");
   chk_flag_sticky: assert property (@(posedge clk) disable iff (!nrst) // see (R2)
      ctl_r[CAM_CTL_OVF] && !ctl_wr |=> ctl_r[CAM_CTL_OVF])
      else $error("overflow flag cleared without a write");
   chk_irq_mask: assert property (@(posedge clk) disable iff (!nrst) // see (R3)
      !mode_r[CAM_MODE_OVF_IE] && (ctl_r[CAM_NUM_MOD-1:0] & module_irq_enable) == 5'h00 |=> !irq_r)
      else $error("interrupt raised while masked");
   chk_ovf_irq: assert property (@(posedge clk) disable iff (!nrst) // see (R3)
      mode_r[CAM_MODE_OVF_IE] && ctl_r[CAM_CTL_OVF] |=> irq_r)
      else $error("enabled overflow gave no interrupt");
   chk_stopped_hold: assert property (@(posedge clk) disable iff (!nrst) // see (R4)
      !ctl_r[CAM_CTL_RUN] && !wd_en |=> $stable(counter_r))
      else $error("counter moved while stopped");
   chk_unused_zero: assert property (@(posedge clk) disable iff (!nrst) // see (R7)
      !ctl_r[CAM_CTL_UNUSED] && !mode_r[CAM_MODE_UNUSED])
      else $error("unused bit set");
   chk_idle_freeze: assert property (@(posedge clk) disable iff (!nrst) // see (R8)
      mode_r[CAM_MODE_IDLE] && cpu_idle |=> $stable(counter_r))
      else $error("counter moved in idle suspend");
   chk_lock_hold: assert property (@(posedge clk) disable iff (!nrst) // see (R10)
      mode_r[CAM_MODE_LOCK] |=> mode_r[CAM_MODE_WDE])
      else $error("locked watchdog was disabled");
   chk_mode_frozen: assert property (@(posedge clk) disable iff (!nrst) // see (R14)
      wd_en |=> mode_r[CAM_MODE_IDLE] == $past(mode_r[CAM_MODE_IDLE]) &&
                mode_r[CAM_MODE_LOCK:0] == $past(mode_r[CAM_MODE_LOCK:0]))
      else $error("mode bit changed with watchdog on");
   chk_count_step: assert property (@(posedge clk) disable iff (!nrst) // see (R19)
      tick |=> counter_r == $past(counter_r) + 16'h0001)
      else $error("counter did not step by one");
   chk_force_reset: assert property (@(posedge clk) disable iff (!nrst) // see (R18)
      wd_en && ctl_wr && sfr.wdata[CAM_CTL_MOD4] |=> watchdog_reset_r)
      else $error("forced watchdog reset missing");

   // ----------------------------------------------------------------------
   // Checks on flags, timebase and watchdog
   // ----------------------------------------------------------------------
   chk_module_flag_set: assert property (@(posedge clk) disable iff (!nrst) // see (R5)
      active && module_match != '0 |=> (ctl_r[CAM_NUM_MOD-1:0] & $past(module_match)) == $past(module_match))
      else $error("module flag not set on match");
   chk_mod_flag_sticky: assert property (@(posedge clk) disable iff (!nrst) // see (R2)
      !ctl_wr |=> (ctl_r[CAM_NUM_MOD-1:0] & $past(ctl_r[CAM_NUM_MOD-1:0])) == $past(ctl_r[CAM_NUM_MOD-1:0]))
      else $error("module flag cleared without a write");
   chk_module_irq: assert property (@(posedge clk) disable iff (!nrst) // see (R6)
      (ctl_r[CAM_NUM_MOD-1:0] & module_irq_enable) != '0 |=> irq_r)
      else $error("enabled module flag gave no interrupt");
   chk_wd_disabled: assert property (@(posedge clk) disable iff (!nrst) // see (R9)
      !wd_en |=> !watchdog_reset_r)
      else $error("watchdog reset while disabled");
   chk_wd_match_reset: assert property (@(posedge clk) disable iff (!nrst) // see (R16)
      wd_en && tick && counter_r[7:0] == CAM_LOW_MAX && module4_compare_high == counter_r[15:8] |=> watchdog_reset_r)
      else $error("watchdog match gave no reset");
   chk_wd_forced_run: assert property (@(posedge clk) disable iff (!nrst) // see (R17)
      wd_en && !ctl_r[CAM_CTL_RUN] && active && presc_r == CAM_DIV12_LAST &&
      mode_r[CAM_MODE_TB_HI:CAM_MODE_TB_LO] == CAM_TB_DIV12 |=> counter_r == $past(counter_r) + 16'h0001)
      else $error("watchdog did not keep the counter running");
   chk_reserved_no_tick: assert property (@(posedge clk) disable iff (!nrst) // see (R11)
      mode_r[CAM_MODE_TB_HI] && mode_r[CAM_MODE_TB_HI-1] |=> $stable(counter_r))
      else $error("counter moved on a reserved timebase");
   chk_system_clock_step: assert property (@(posedge clk) disable iff (!nrst) // see (R11)
      ctl_r[CAM_CTL_RUN] && active && mode_r[CAM_MODE_TB_HI:CAM_MODE_TB_LO] == CAM_TB_SYSTEM_CLOCK |=>
      counter_r == $past(counter_r) + 16'h0001)
      else $error("system clock timebase missed a step");
   chk_timer0_step: assert property (@(posedge clk) disable iff (!nrst) // see (R11)
      ctl_r[CAM_CTL_RUN] && active && timer0_overflow && mode_r[CAM_MODE_TB_HI:CAM_MODE_TB_LO] == CAM_TB_TMR0 |=>
      counter_r == $past(counter_r) + 16'h0001)
      else $error("timer 0 overflow not counted");
   chk_extin_fall: assert property (@(posedge clk) disable iff (!nrst) // see (R12)
      ctl_r[CAM_CTL_RUN] && active && eci_sync_r[2] && !eci_sync_r[1] &&
      mode_r[CAM_MODE_TB_HI:CAM_MODE_TB_LO] == CAM_TB_EXTIN |=> counter_r == $past(counter_r) + 16'h0001)
      else $error("falling count input not counted");
   chk_extclk_div: assert property (@(posedge clk) disable iff (!nrst) // see (R13)
      mode_r[CAM_MODE_TB_HI:CAM_MODE_TB_LO] == CAM_TB_EXTCLK && ext_div_r != CAM_EXT_DIV_LAST |=> $stable(counter_r))
      else $error("external clock counted before the eighth edge");
   chk_unlocked_clear: assert property (@(posedge clk) disable iff (!nrst) // see (R14)
      wd_en && !mode_r[CAM_MODE_LOCK] && mode_wr && !sfr.wdata[CAM_MODE_WDE] |=> !mode_r[CAM_MODE_WDE])
      else $error("unlocked watchdog could not be disabled");
   chk_mode_write_open: assert property (@(posedge clk) disable iff (!nrst) // see (R14)
      !wd_en && mode_wr |=>
      mode_r[CAM_MODE_TB_HI:CAM_MODE_TB_LO] == $past(sfr.wdata[CAM_MODE_TB_HI:CAM_MODE_TB_LO]))
      else $error("timebase write lost with watchdog off");
   chk_ovf_clear: assert property (@(posedge clk) disable iff (!nrst) // see (R2)
      ctl_wr && !sfr.wdata[CAM_CTL_OVF] && !(tick && counter_r == CAM_CNT_MAX) |=> !ctl_r[CAM_CTL_OVF])
      else $error("software clear of overflow flag lost");
   chk_idle_flags: assert property (@(posedge clk) disable iff (!nrst) // see (R8)
      mode_r[CAM_MODE_IDLE] && cpu_idle && !ctl_wr |=> ctl_r[CAM_NUM_MOD-1:0] == $past(ctl_r[CAM_NUM_MOD-1:0]))
      else $error("module flag changed in idle suspend");

endmodule : cam_ctrl

// ==== test/tb.sv ====
// Self-checking testbench of the counter array control and mode block.
`timescale 1ns/10ps
module tb;
   import cam_pkg::*;
   localparam logic [7:0] CT = CAM_CTL_ADDR;
   localparam logic [7:0] MD = CAM_MODE_ADDR;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   cam_sfr_t sfr = '0;
   logic [4:0] mm = '0;
   logic [4:0] mie = '0;
   logic idle = 1'b0;
   logic [7:0] cmp = 8'hff;
   logic [7:0] cyc = '0;
   logic [7:0] rd;
   logic s;
   logic [7:0] sfr_rdata_r;
   logic [15:0] counter_r;
   logic irq_r;
   logic watchdog_reset_r;
   int failures = 0;
   int total_checks = 0;
   always #25 clk = ~clk;
   // Timer 0 pulses every 8 cycles, count input falls every 16, external clock period is 8.
   always @(negedge clk) cyc <= cyc + 8'h01;
   cam_ctrl u_cam_ctrl (.clk(clk), .nrst(nrst), .sfr(sfr), .sfr_rdata_r(sfr_rdata_r), .module_match(mm),
      .module_irq_enable(mie), .timer0_overflow(cyc[2:0] == 3'h0), .cpu_idle(idle),
      .module4_compare_high(cmp), .external_count_input(cyc[3]), .external_clock(cyc[2]),
      .counter_r(counter_r), .irq_r(irq_r), .watchdog_reset_r(watchdog_reset_r));
   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chkb(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chkb
   task automatic results;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_n
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk);
      sfr <= '0;
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      @(negedge clk);
      sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk);
      sfr <= '0;
      rd = sfr_rdata_r;
   endtask : rdr
   task automatic wd_pulse(input int n);
      s = watchdog_reset_r === 1'b1;
      repeat (n) begin
         @(negedge clk);
         if (watchdog_reset_r === 1'b1) s = 1'b1;
      end
   endtask : wd_pulse
   task automatic rate(input int n, input int lo, input int hi);
      logic [15:0] c0;
      logic [15:0] d;
      wait_n(2);
      c0 = counter_r;
      wait_n(n);
      d = counter_r - c0;
      chkb(d >= 16'(lo) && d <= 16'(hi), 1'b1);
   endtask : rate
   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_watchdog;
      wr(MD, 8'hc9);
      rdr(MD);
      chk(rd, 8'h40);
      rate(48, 3, 5);
      cmp = 8'h00;
      wd_pulse(3300);
      chkb(s, 1'b1);
      cmp = 8'hff;
      wr(CT, 8'h10);
      wd_pulse(3);
      chkb(s, 1'b1);
      wr(MD, 8'h00);
      rdr(MD);
      chk(rd, 8'h00);
      wr(CT, 8'h10);
      wd_pulse(5);
      chkb(s, 1'b0);
      wr(CT, 8'h20);
      rdr(CT);
      chk(rd, 8'h00);
      wr(MD, 8'h10);
      rdr(MD);
      chk(rd, 8'h00);
   endtask : t_watchdog
   task automatic t_flags;
      for (int i = 0; i < 5; i++) begin
         mie = 5'h01 << i;
         mm <= 5'h01 << i;
         @(negedge clk);
         mm <= '0;
         wait_n(4);
         rdr(CT);
         chk(rd, 8'h01 << i);
         chkb(irq_r, 1'b1);
         mie = '0;
         wait_n(2);
         chkb(irq_r, 1'b0);
         wr(CT, 8'h00);
         rdr(CT);
         chk(rd, 8'h00);
      end
   endtask : t_flags
   task automatic t_timebase;
      int lo[8] = '{19, 59, 29, 14, 239, 3, 0, 0};
      int hi[8] = '{21, 61, 31, 16, 241, 5, 0, 0};
      wr(CT, 8'h40);
      for (int t = 0; t < 8; t++) begin
         wr(MD, 8'(t << 1));
         rate(240, lo[t], hi[t]);
      end
      wr(MD, 8'h08);
      wr(CT, 8'h00);
      rate(20, 0, 0);
      wr(CT, 8'h40);
      idle = 1'b1;
      rate(20, 19, 21);
      wr(MD, 8'h88);
      rate(20, 0, 0);
      idle = 1'b0;
      rate(20, 19, 21);
   endtask : t_timebase
   task automatic t_overflow;
      int n;
      wr(MD, 8'h09);
      n = 0;
      while (counter_r !== CAM_CNT_MAX && n < 70000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 70000) begin
         chkb(1'b0, 1'b1);
      end else begin
         wait_n(3);
         rdr(CT);
         chk(rd, 8'hc0);
         chkb(irq_r, 1'b1);
         wr(MD, 8'h08);
         wait_n(2);
         chkb(irq_r, 1'b0);
         wr(MD, 8'h09);
         wr(CT, 8'h40);
         wait_n(2);
         chkb(irq_r, 1'b0);
         rdr(CT);
         chk(rd, 8'h40);
      end
   endtask : t_overflow
   task automatic t_lock;
      wr(MD, 8'h20);
      rdr(MD);
      chk(rd, 8'h60);
      wr(MD, 8'h00);
      rdr(MD);
      chk(rd, 8'h60);
      nrst = 1'b0;
      wait_n(5);
      nrst = 1'b1;
      rdr(MD);
      chk(rd, 8'h40);
   endtask : t_lock
   initial begin
      wait_n(5);
      nrst = 1'b1;
      rdr(CT);
      chk(rd, 8'h00);
      rdr(MD);
      chk(rd, 8'h40);
      t_watchdog();
      t_flags();
      t_timebase();
      t_overflow();
      t_lock();
      results();
   end
endmodule : tb
